// file: core/tcbb_pkg.sv
// =====================================================================
// timer/counter constants
package tcbb_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int NUM_CMP = 3;
  localparam int NUM_WO = 6;
  localparam int PRESC_W = 10;

  // =====================================================================
  // register indices on the plain register port
  localparam logic [3:0] ADDR_CONTROL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam logic [3:0] ADDR_COUNT = 4'h2;
  localparam logic [3:0] ADDR_PERIOD = 4'h3;
  localparam logic [3:0] ADDR_PERIOD_BUF = 4'h4;
  localparam logic [3:0] ADDR_CMP0 = 4'h5;
  localparam logic [3:0] ADDR_CMP_BUF0 = 4'h8;

  // =====================================================================
  // control register fields
  localparam int CTL_ENABLE = 0;
  localparam int CTL_CLOCK_SELECT_LO = 1;
  localparam int CTL_CLOCK_SELECT_W = 3;
  localparam int CTL_SPLIT = 4;
  localparam int CTL_DIR_DOWN = 5;
  localparam int CTL_COUNT_EVENT = 6;
  localparam int CTL_DEBUG_RUN = 7;
  localparam int CTL_UPD_BOTTOM = 8;
  localparam int CTL_EV_DIR_EN = 9;
  localparam int CTL_EV_RESTART_EN = 10;
  localparam int CTL_W = 11;

  // =====================================================================
  // status register fields
  localparam int STS_PER_BV = 0;
  localparam int STS_CMP_BV_LO = 1;
  localparam int STS_OVF = 4;
  localparam int STS_CMP_LO = 5;

  // =====================================================================
  // reset values
  localparam logic [15:0] RST_PERIOD = 16'hffff;
  localparam logic [15:0] RST_ZERO = 16'h0000;
  localparam logic [10:0] RST_CONTROL = 11'h000;

  // =====================================================================
  // event input bit positions in the synchroniser vector
  localparam int EV_COUNT = 0;
  localparam int EV_DIR = 1;
  localparam int EV_RESTART = 2;
  localparam int EV_HALT = 3;
  localparam int EV_W = 4;
endpackage : tcbb_pkg

// file: core/tcbb_timer.sv
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps
module tcbb_timer (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic eventCount,
  input wire logic eventDir,
  input wire logic eventRestart,
  input wire logic debugHalt,
  output logic [5:0] waveformOut,
  output logic irqOverflow,
  output logic [2:0] irqCompare
);

  // =====================================================================
  // helpers
  // prescaler mask: the tick fires when all masked bits are ones
  function automatic logic [9:0] presc_mask(input logic [2:0] sel);
    logic [9:0] m;
    m = 10'h000;
    unique case (sel)
      3'h0: m = 10'h000;
      3'h1: m = 10'h001;
      3'h2: m = 10'h003;
      3'h3: m = 10'h007;
      3'h4: m = 10'h00f;
      3'h5: m = 10'h03f;
      3'h6: m = 10'h0ff;
      3'h7: m = 10'h3ff;
    endcase
    return m;
  endfunction : presc_mask

  // per-byte copy so split halves update independently
  function automatic logic [15:0] byte_merge(input logic [15:0] oldV, input logic [15:0] newV,
                                             input logic lo, input logic hi);
    logic [15:0] r;
    r = oldV;
    if (lo)
    begin
      r[7:0] = newV[7:0];
    end
    if (hi)
    begin
      r[15:8] = newV[15:8];
    end
    return r;
  endfunction : byte_merge

  // =====================================================================
  // storage
  logic [10:0] control;
  logic [15:0] countValue;
  logic [15:0] period;
  logic [15:0] periodBuffer;
  logic periodBufferValid;
  logic [15:0] compareValue [3];
  logic [15:0] compareBuffer [3];
  logic [2:0] compareBufferValid;
  logic [9:0] presc;
  logic [3:0] syncA;
  logic [3:0] syncB;
  logic [3:0] evPrev;

  // =====================================================================
  // decode
  logic enable;
  logic splitMode;
  logic dirDown;
  logic countOnEventEnable;
  logic debugRun;
  logic updOnBottom;
  logic run;
  logic prescTick;
  logic evCountEdge;
  logic evRestartEdge;
  logic tick;
  logic atTop;
  logic atBottom;
  logic loBottom;
  logic hiBottom;
  logic updLo;
  logic updHi;
  logic wrCount;
  logic wrPeriod;
  logic wrPeriodBuf;
  logic wrStatus;
  logic [2:0] wrCmp;
  logic [2:0] wrCmpBuf;
  logic [2:0] matchLo;
  logic [2:0] matchHi;

  assign enable = control[tcbb_pkg::CTL_ENABLE];
  assign splitMode = control[tcbb_pkg::CTL_SPLIT];
  assign countOnEventEnable = control[tcbb_pkg::CTL_COUNT_EVENT];
  assign debugRun = control[tcbb_pkg::CTL_DEBUG_RUN];
  assign updOnBottom = control[tcbb_pkg::CTL_UPD_BOTTOM];
  // event level overrides the direction bit when so enabled
  assign dirDown = control[tcbb_pkg::CTL_EV_DIR_EN] ? syncB[tcbb_pkg::EV_DIR]
                                                   : control[tcbb_pkg::CTL_DIR_DOWN];

  assign run = enable && (!syncB[tcbb_pkg::EV_HALT] || debugRun);
  assign prescTick = (presc & presc_mask(control[tcbb_pkg::CTL_CLOCK_SELECT_LO +: 3]))
                     == presc_mask(control[tcbb_pkg::CTL_CLOCK_SELECT_LO +: 3]);
  assign evCountEdge = syncB[tcbb_pkg::EV_COUNT] && !evPrev[tcbb_pkg::EV_COUNT];
  assign evRestartEdge = syncB[tcbb_pkg::EV_RESTART] && !evPrev[tcbb_pkg::EV_RESTART];
  assign tick = run && (countOnEventEnable ? evCountEdge : prescTick);

  assign atTop = countValue == period;
  assign atBottom = countValue == tcbb_pkg::RST_ZERO;
  assign loBottom = countValue[7:0] == 8'h00;
  assign hiBottom = countValue[15:8] == 8'h00;

  // split halves only count down, so each updates at its own bottom
  assign updLo = tick && (splitMode ? loBottom : (updOnBottom ? atBottom : atTop));
  assign updHi = tick && (splitMode ? hiBottom : (updOnBottom ? atBottom : atTop));

  assign wrCount = regWrite && regAddr == tcbb_pkg::ADDR_COUNT;
  assign wrPeriod = regWrite && regAddr == tcbb_pkg::ADDR_PERIOD;
  assign wrPeriodBuf = regWrite && regAddr == tcbb_pkg::ADDR_PERIOD_BUF;
  assign wrStatus = regWrite && regAddr == tcbb_pkg::ADDR_STATUS;

  always_comb
  begin
    for (int i = 0; i < tcbb_pkg::NUM_CMP; i++)
    begin
      wrCmp[i] = regWrite && regAddr == tcbb_pkg::ADDR_CMP0 + 4'(i);
      wrCmpBuf[i] = regWrite && regAddr == tcbb_pkg::ADDR_CMP_BUF0 + 4'(i);
      matchLo[i] = splitMode ? countValue[7:0] == compareValue[i][7:0]
                             : countValue == compareValue[i];
      matchHi[i] = splitMode && countValue[15:8] == compareValue[i][15:8];
    end
  end

  // =====================================================================
  // input synchronisers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      syncA <= 4'h0;
      syncB <= 4'h0;
      evPrev <= 4'h0;
    end
    else
    begin
      syncA <= {debugHalt, eventRestart, eventDir, eventCount};
      syncB <= syncA;
      evPrev <= syncB;
    end
  end

  // =====================================================================
  // prescaler
  // free-running while run is set; cleared when disabled or halted so ratio starts clean
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc <= 10'h000;
    end
    else if (!run)
    begin
      presc <= 10'h000;
    end
    else
    begin
      presc <= presc + 10'h001;
    end
  end

  // =====================================================================
  // control register
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control <= tcbb_pkg::RST_CONTROL;
    end
    else if (regWrite && regAddr == tcbb_pkg::ADDR_CONTROL)
    begin
      control <= regWdata[10:0];
    end
  end

  // =====================================================================
  // counter
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      countValue <= tcbb_pkg::RST_ZERO;
    end
    else if (wrCount)
    begin
      countValue <= regWdata;
    end
    else if (run && control[tcbb_pkg::CTL_EV_RESTART_EN] && evRestartEdge)
    begin
      countValue <= tcbb_pkg::RST_ZERO;
    end
    else if (tick && splitMode)
    begin
      countValue[7:0] <= loBottom ? period[7:0] : countValue[7:0] - 8'h01;
      countValue[15:8] <= hiBottom ? period[15:8] : countValue[15:8] - 8'h01;
    end
    else if (tick && dirDown)
    begin
      countValue <= atBottom ? period : countValue - 16'h0001;
    end
    else if (tick)
    begin
      countValue <= atTop ? tcbb_pkg::RST_ZERO : countValue + 16'h0001;
    end
  end

  // =====================================================================
  // period and its buffer
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      period <= tcbb_pkg::RST_PERIOD;
      periodBuffer <= tcbb_pkg::RST_PERIOD;
      periodBufferValid <= 1'b0;
    end
    else
    begin
      if (wrPeriod)
      begin
        period <= regWdata;
      end
      else if (periodBufferValid)
      begin
        period <= byte_merge(period, periodBuffer, updLo, updHi);
      end
      if (wrPeriodBuf)
      begin
        periodBuffer <= regWdata;
      end
      // a buffer write in the update cycle keeps the flag set
      if (wrPeriodBuf)
      begin
        periodBufferValid <= 1'b1;
      end
      else if (updLo)
      begin
        periodBufferValid <= 1'b0;
      end
    end
  end

  // =====================================================================
  // compare channels and their buffers
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < tcbb_pkg::NUM_CMP; i++)
      begin
        compareValue[i] <= tcbb_pkg::RST_ZERO;
        compareBuffer[i] <= tcbb_pkg::RST_ZERO;
      end
      compareBufferValid <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < tcbb_pkg::NUM_CMP; i++)
      begin
        if (wrCmp[i])
        begin
          compareValue[i] <= regWdata;
        end
        else if (compareBufferValid[i])
        begin
          compareValue[i] <= byte_merge(compareValue[i], compareBuffer[i], updLo, updHi);
        end
        if (wrCmpBuf[i])
        begin
          compareBuffer[i] <= regWdata;
          compareBufferValid[i] <= 1'b1;
        end
        else if (updLo)
        begin
          compareBufferValid[i] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // interrupt request flags, write one to clear, hardware set wins
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqOverflow <= 1'b0;
      irqCompare <= 3'h0;
    end
    else
    begin
      if (updLo || updHi)
      begin
        irqOverflow <= 1'b1;
      end
      else if (wrStatus && regWdata[tcbb_pkg::STS_OVF])
      begin
        irqOverflow <= 1'b0;
      end
      for (int i = 0; i < tcbb_pkg::NUM_CMP; i++)
      begin
        if (tick && (matchLo[i] || matchHi[i]))
        begin
          irqCompare[i] <= 1'b1;
        end
        else if (wrStatus && regWdata[tcbb_pkg::STS_CMP_LO + i])
        begin
          irqCompare[i] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // waveform outputs 2:0, and 5:3 in split mode: high while count is below the compare value
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      waveformOut <= 6'h00;
    end
    else
    begin
      for (int i = 0; i < tcbb_pkg::NUM_CMP; i++)
      begin
        if (splitMode)
        begin
          waveformOut[i] <= countValue[7:0] < compareValue[i][7:0];
          waveformOut[i + 3] <= countValue[15:8] < compareValue[i][15:8];
        end
        else
        begin
          waveformOut[i] <= countValue < compareValue[i];
          waveformOut[i + 3] <= 1'b0;
        end
      end
    end
  end

  // =====================================================================
  // register read port, data one cycle after the strobe
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      regRdata <= 16'h0000;
    end
    else if (!regRead)
    begin
      regRdata <= 16'h0000;
    end
    else
    begin
      unique case (regAddr)
        tcbb_pkg::ADDR_CONTROL: regRdata <= {5'h00, control};
        tcbb_pkg::ADDR_STATUS: regRdata <= {8'h00, irqCompare, irqOverflow,
                                            compareBufferValid, periodBufferValid};
        tcbb_pkg::ADDR_COUNT: regRdata <= countValue;
        tcbb_pkg::ADDR_PERIOD: regRdata <= period;
        tcbb_pkg::ADDR_PERIOD_BUF: regRdata <= periodBuffer;
        4'h5: regRdata <= compareValue[0];
        4'h6: regRdata <= compareValue[1];
        4'h7: regRdata <= compareValue[2];
        4'h8: regRdata <= compareBuffer[0];
        4'h9: regRdata <= compareBuffer[1];
        4'ha: regRdata <= compareBuffer[2];
        default: regRdata <= 16'h0000;
      endcase
    end
  end

endmodule : tcbb_timer

// file: dv/tcbb_timer_sva.sv
`timescale 1ns/1ps
// ==========================================
// port-level checks
module tcbb_timer_chk (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regRdata,
  input wire logic debugHalt,
  input wire logic [5:0] waveformOut,
  input wire logic irqOverflow,
  input wire logic [2:0] irqCompare
);
  logic [10:0] ctl;
  logic stsWr;
  assign stsWr = regWrite && regAddr == tcbb_pkg::ADDR_STATUS;
  // shadow of the control register, rebuilt from bus writes
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
      ctl <= tcbb_pkg::RST_CONTROL;
    else if (regWrite && regAddr == tcbb_pkg::ADDR_CONTROL)
      ctl <= regWdata[10:0];
  default clocking @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  chk_rdata_idle: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data not idle");
  chk_ctl_readback: assert property (regRead && regAddr == tcbb_pkg::ADDR_CONTROL
    |=> regRdata == {5'h00, $past(ctl)})
    else $error("control read back wrong");
  chk_ovf_sticky: assert property (irqOverflow && !(stsWr && regWdata[4]) |=> irqOverflow)
    else $error("overflow flag dropped");
  chk_cmp_sticky: assert property (!stsWr |=> (irqCompare & $past(irqCompare)) == $past(irqCompare))
    else $error("compare flag dropped");
  chk_ovf_clear: assert property (stsWr && regWdata[4] && !ctl[0] |=> !irqOverflow)
    else $error("overflow flag not cleared");
  chk_idle_quiet: assert property (!ctl[0] |=> !$rose(irqOverflow)
    && (irqCompare & ~$past(irqCompare)) == 3'h0)
    else $error("flag set while disabled");
  chk_halt_freeze: assert property ((debugHalt && !ctl[7])[*4] |=> !$rose(irqOverflow)
    && (irqCompare & ~$past(irqCompare)) == 3'h0)
    else $error("flag set while halted");
  chk_wave_split: assert property (!ctl[4] && !$past(ctl[4]) |-> waveformOut[5:3] == 3'h0)
    else $error("upper outputs active outside split");
endmodule : tcbb_timer_chk

// file: dv/tcbb_evsys_model.sv
`timescale 1ns/1ps
// ==========================================
// event source: n pulses, 4 cycles high, 4 low
module tcbb_evsys_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic go,
  input wire logic toRestart,
  input wire logic downReq,
  input wire logic [3:0] nPulses,
  output logic eventCount,
  output logic eventDir,
  output logic eventRestart,
  output logic busy
);
  logic [2:0] phase;
  logic [3:0] left;
  assign busy = left != 4'h0;
  always_ff @(posedge clock or negedge rst_n)
    if (!rst_n)
    begin
      left <= 4'h0;
      phase <= 3'h0;
    end
    else if (go)
    begin
      left <= nPulses;
      phase <= 3'h0;
    end
    else if (busy)
    begin
      phase <= phase + 3'h1;
      if (phase == 3'h7)
        left <= left - 4'h1;
    end
  // long pulses so the two-flop input sync never misses one
  assign eventCount = busy && !toRestart && !phase[2];
  assign eventRestart = busy && toRestart && !phase[2];
  assign eventDir = downReq;
endmodule : tcbb_evsys_model

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] regAddr = 4'h0;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic debugHalt = 1'b0;
  logic evGo = 1'b0;
  logic evRst = 1'b0;
  logic evDown = 1'b0;
  logic [3:0] evN = 4'h0;
  logic [15:0] regRdata;
  logic [5:0] waveformOut;
  logic [2:0] irqCompare;
  logic irqOverflow, eventCount, eventDir, eventRestart, evBusy;
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  always #25 clock = ~clock;
  tcbb_timer dut (.clock(clock), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .eventCount(eventCount),
    .eventDir(eventDir), .eventRestart(eventRestart), .debugHalt(debugHalt),
    .waveformOut(waveformOut), .irqOverflow(irqOverflow), .irqCompare(irqCompare));
  tcbb_evsys_model evs (.clock(clock), .rst_n(rst_n), .go(evGo), .toRestart(evRst),
    .downReq(evDown), .nPulses(evN), .eventCount(eventCount), .eventDir(eventDir),
    .eventRestart(eventRestart), .busy(evBusy));
  task automatic summarize();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fail_count++;
      summarize();
    end
  end
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : chk
  // every access takes two cycles so no strobe is assigned twice in one step
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    regWrite <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clock);
    regWrite <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    regRead <= 1'b1;
    regAddr <= a;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    d = regRdata;
  endtask : rd
  task automatic pulses(input logic [3:0] n, input logic r);
    evN <= n;
    evRst <= r;
    evGo <= 1'b1;
    @(posedge clock);
    evGo <= 1'b0;
    @(posedge clock);
    for (int k = 0; k < 200 && evBusy !== 1'b0; k++)
      @(posedge clock);
    repeat (4) @(posedge clock);
  endtask : pulses
  function automatic logic [15:0] step(input logic [15:0] v, input logic [15:0] p, input logic dn);
    if (dn)
      return (v == 16'h0000) ? p : v - 16'h0001;
    return (v == p) ? 16'h0000 : v + 16'h0001;
  endfunction : step
  // split halves count down on their own and reload from their period byte
  function automatic logic [15:0] sstep(input logic [15:0] v, input logic [15:0] p);
    return {(v[15:8] == 8'h00) ? p[15:8] : v[15:8] - 8'h01,
            (v[7:0] == 8'h00) ? p[7:0] : v[7:0] - 8'h01};
  endfunction : sstep
  initial
  begin
    logic [15:0] r, q, p, x;
    logic [15:0] cv [3];
    logic [5:0] w;
    void'($urandom(32'hf72bb6e6));
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    for (int a = 0; a < 11; a++)
    begin
      rd(4'(a), r);
      chk("reset value", (a == 3 || a == 4) ? 16'hffff : 16'h0000, r);
    end
    wr(4'hf, 16'($urandom));
    rd(4'hf, r);
    chk("unmapped", 16'h0000, r);
    $display("test reset done");
    // ==========================================
    // buffered period and compares
    x = 16'h0020 + 16'($urandom_range(4000));
    wr(tcbb_pkg::ADDR_PERIOD, 16'h0010);
    wr(tcbb_pkg::ADDR_PERIOD_BUF, x);
    for (int i = 0; i < 3; i++)
    begin
      cv[i] = 16'($urandom);
      wr(tcbb_pkg::ADDR_CMP0 + 4'(i), 16'h0004 + 16'(i));
      wr(tcbb_pkg::ADDR_CMP_BUF0 + 4'(i), cv[i]);
    end
    rd(tcbb_pkg::ADDR_STATUS, r);
    chk("valid flags", 16'h000f, r);
    rd(tcbb_pkg::ADDR_PERIOD, r);
    chk("period held", 16'h0010, r);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0001);
    repeat (8) @(posedge clock);
    rd(tcbb_pkg::ADDR_PERIOD, r);
    chk("period before wrap", 16'h0010, r);
    // count reaches TOP 16 ticks after enable; stop only once the wrap is past
    repeat (16) @(posedge clock);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0000);
    rd(tcbb_pkg::ADDR_PERIOD, r);
    chk("period copied", x, r);
    w = 6'h00;
    rd(tcbb_pkg::ADDR_COUNT, q);
    for (int i = 0; i < 3; i++)
    begin
      rd(tcbb_pkg::ADDR_CMP0 + 4'(i), r);
      chk("compare copied", cv[i], r);
      w[i] = q < cv[i];
    end
    chk("waveform", {10'h000, w}, {10'h000, waveformOut});
    rd(tcbb_pkg::ADDR_STATUS, r);
    chk("flags after update", 16'h00f0, r);
    wr(tcbb_pkg::ADDR_STATUS, 16'h00f0);
    rd(tcbb_pkg::ADDR_STATUS, r);
    chk("flags cleared", 16'h0000, r);
    $display("test buffering done");
    // ==========================================
    // direction, wrap and reload
    p = 16'h0003 + 16'($urandom_range(9));
    wr(tcbb_pkg::ADDR_PERIOD, p);
    wr(tcbb_pkg::ADDR_COUNT, 16'h0000);
    for (int d = 0; d < 2; d++)
    begin
      wr(tcbb_pkg::ADDR_CONTROL, d ? 16'h0021 : 16'h0001);
      rd(tcbb_pkg::ADDR_COUNT, q);
      repeat (8)
      begin
        rd(tcbb_pkg::ADDR_COUNT, r);
        chk("count step", step(step(q, p, d[0]), p, d[0]), r);
        q = r;
      end
    end
    $display("test direction done");
    // ==========================================
    // prescaler ratios and count write
    wr(tcbb_pkg::ADDR_PERIOD, 16'hffff);
    for (int i = 0; i < 4; i++)
    begin
      wr(tcbb_pkg::ADDR_CONTROL, 16'(2 * i + 1));
      rd(tcbb_pkg::ADDR_COUNT, q);
      repeat (8) rd(tcbb_pkg::ADDR_COUNT, r);
      chk("ticks in 16 cycles", 16'(16 >> i), r - q);
    end
    // divide by one: the write edge also ticks, so the write must win over it
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0001);
    x = 16'($urandom_range(16'hff00));
    wr(tcbb_pkg::ADDR_COUNT, x);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("count write", x + 16'h0001, r);
    $display("test prescaler done");
    // ==========================================
    // event counting, direction and restart
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0041);
    wr(tcbb_pkg::ADDR_COUNT, 16'h0000);
    pulses(4'h3, 1'b0);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("event count", 16'h0003, r);
    evDown <= 1'b1;
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0241);
    pulses(4'h2, 1'b0);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("event down", 16'h0001, r);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0441);
    wr(tcbb_pkg::ADDR_COUNT, 16'h0009);
    pulses(4'h1, 1'b1);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("event restart", 16'h0000, r);
    $display("test events done");
    // ==========================================
    // debug halt
    debugHalt <= 1'b1;
    // let the halt clear the input synchroniser before enabling
    repeat (2) @(posedge clock);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0001);
    repeat (10) @(posedge clock);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("halted count", 16'h0000, r);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0081);
    rd(tcbb_pkg::ADDR_COUNT, r);
    chk("debug run", 16'h0001, {15'h0000, r != 16'h0000});
    $display("test debug done");
    // ==========================================
    // split: two independent down-counting bytes
    debugHalt <= 1'b0;
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0000);
    p = {8'h02 + 8'($urandom_range(5)), 8'h03 + 8'($urandom_range(9))};
    wr(tcbb_pkg::ADDR_PERIOD, p);
    wr(tcbb_pkg::ADDR_COUNT, 16'h0000);
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0011);
    rd(tcbb_pkg::ADDR_COUNT, q);
    repeat (8)
    begin
      rd(tcbb_pkg::ADDR_COUNT, r);
      chk("split count", sstep(sstep(q, p), p), r);
      q = r;
    end
    wr(tcbb_pkg::ADDR_CONTROL, 16'h0010);
    rd(tcbb_pkg::ADDR_COUNT, q);
    for (int i = 0; i < 3; i++)
    begin
      w[i] = q[7:0] < cv[i][7:0];
      w[i + 3] = q[15:8] < cv[i][15:8];
    end
    chk("split waveform", {10'h000, w}, {10'h000, waveformOut});
    $display("test split done");
    summarize();
  end
endmodule : tb
bind tcbb_timer tcbb_timer_chk chk (.clock(clock), .rst_n(rst_n), .regAddr(regAddr),
  .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .debugHalt(debugHalt), .waveformOut(waveformOut), .irqOverflow(irqOverflow),
  .irqCompare(irqCompare));
